// ### dv/gwwe_checker.sv
// assertions on the bus and gamma ports of the window write engine
`timescale 1ns/1ps
module gwwe_checker (
  input wire        i_clock,     // core clock
  input wire        i_rstn,      // async reset, active low
  input wire        i_wb_cyc,    // bus cycle
  input wire        i_wb_stb,    // bus strobe
  input wire        i_wb_we,     // bus write
  input wire [7:0]  i_wb_adr,    // bus address
  input wire [3:0]  i_wb_sel,    // byte lanes
  input wire [31:0] i_wb_dat,    // write data
  input wire [31:0] o_wb_dat,    // read data
  input wire        o_wb_ack,    // acknowledge
  input wire [25:0] o_gamma_set  // active gamma set
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  reg  [7:0]  sh_ctl;
  reg  [25:0] sh_pos;
  reg  [25:0] sh_neg;
  wire        wr_hit;
  wire        rd_hit;
  wire        chg;
  // shadow only follows full-lane writes, the only kind the host issues
  assign wr_hit = o_wb_ack && i_wb_cyc && i_wb_we && i_wb_sel == 4'hf;
  assign rd_hit = o_wb_ack && !i_wb_we;
  assign chg    = wr_hit && (i_wb_adr == 8'h00 || i_wb_adr[7:4] == 4'h2);
  // settings as the bus last wrote them
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_ctl <= 8'h02;
      sh_pos <= 26'h0;
      sh_neg <= 26'h0;
    end else if (wr_hit) begin
      if (i_wb_adr == 8'h00) sh_ctl <= i_wb_dat[7:0];
      if (i_wb_adr == 8'h20) sh_pos <= i_wb_dat[25:0];
      if (i_wb_adr == 8'h24) sh_neg <= i_wb_dat[25:0];
    end
  end
  sequence ack_wait_s;
    ##[1:40] o_wb_ack;
  endsequence
  ack_pulse_a: assert property (
    o_wb_ack |=> !o_wb_ack) else $error("ack held two cycles");
  ack_cause_a: assert property (
    o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack unasked");
  ack_in_cyc_a: assert property (
    o_wb_ack |-> i_wb_cyc && i_wb_stb) else $error("ack outside cycle");
  ack_bound_a: assert property (
    $rose(i_wb_cyc && i_wb_stb) |-> ack_wait_s) else $error("no ack");
  unmapped_zero_a: assert property (
    rd_hit && i_wb_adr > 8'h28 |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (
    rd_hit && i_wb_adr == 8'h00 |-> o_wb_dat[7:0] == sh_ctl)
    else $error("control readback wrong");
  gam_read_a: assert property (
    rd_hit && i_wb_adr == 8'h24 |-> o_wb_dat[25:0] == sh_neg)
    else $error("negative gamma readback wrong");
  gamma_sel_a: assert property (
    !$past(chg) |-> o_gamma_set == (sh_ctl[7] ? sh_neg : sh_pos))
    else $error("gamma set does not follow polarity");
endmodule // gwwe_checker

bind gwwe_top gwwe_checker u_gwwe_checker (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_gamma_set(o_gamma_set)
);

// ### dv/gwwe_host.sv
// bus master model standing in for the host microcomputer
`timescale 1ns/1ps
module gwwe_host (
  input  wire        i_clock,  // core clock
  input  wire        i_ack,    // slave acknowledge
  input  wire [31:0] i_rdat,   // slave read data
  output reg         o_cyc,    // cycle
  output reg         o_stb,    // strobe
  output reg         o_we,     // write
  output reg  [7:0]  o_adr,    // address
  output reg  [3:0]  o_sel,    // byte lanes
  output reg  [31:0] o_dat     // write data
);
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'hf;
    o_dat = 32'h0;
  end
  // one classic cycle, held until ack is seen at a rising edge;
  // released lines flip so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= w;
    o_adr <= a;
    o_dat <= d;
    @(posedge i_clock);
    while (i_ack !== 1'b1) @(posedge i_clock);
    q = i_rdat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    o_adr <= ~a;
    o_dat <= ~d;
  endtask
endmodule // gwwe_host

// ### dv/gwwe_top_bench.sv
// self-checking bench for the window write engine
`timescale 1ns/1ps
`include "gwwe_defines.vh"
module gwwe_top_bench;
  reg          i_clock = 1'b0;
  reg          i_rstn  = 1'b0;
  reg  [15:0]  rd_addr = 16'h0;
  wire         cyc, stb, we, ack;
  wire [7:0]   adr;
  wire [3:0]   sel;
  wire [31:0]  wdat, rdat;
  wire [17:0]  rd_data;
  wire [25:0]  gam;
  integer      err_total = 0;
  integer      n_tests = 0;
  logic [31:0] expq[$];
  logic [17:0] m [logic [15:0]];
  logic [17:0] msk, cmp;
  logic [2:0]  lg;
  logic        bst;
  logic [31:0] q;
  always #12.5 i_clock = ~i_clock;
  gwwe_host u_gwwe_host (.i_clock(i_clock), .i_ack(ack), .i_rdat(rdat),
    .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
    .o_dat(wdat));
  gwwe_top u_gwwe_top (.i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_gamma_set(gam));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // read results are matched against the oldest note
  always @(posedge i_clock)
    if (ack === 1'b1 && we === 1'b0) chk(rdat, expq.pop_front());
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_gwwe_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    u_gwwe_host.xfer(1'b0, a, 32'h0, q);
  endtask
  // data word with its expected effect on the ram model
  task automatic put(input logic [15:0] a, input logic [31:0] s,
                     input logic [17:0] x);
    logic [2:0] eq;
    eq = {x[17:12] == cmp[17:12], x[11:6] == cmp[11:6], x[5:0] == cmp[5:0]};
    wr(`GWWE_ADR_DATA, s);
    if (bst || (lg == 3'h6 ? &eq : lg == 3'h7 ? ~|eq : 1'b1))
      m[a] = (m[a] & msk) | (x & ~msk);
  endtask
  // cell checked both on the scan port and through the bus
  task automatic look(input logic [15:0] a);
    wr(`GWWE_ADR_ADDR, {16'h0, a});
    rd_addr <= {8'h0, a[15:8]} * 16'h00b0 + {8'h0, a[7:0]};
    repeat (2) @(posedge i_clock);
    chk({14'h0, rd_data}, {14'h0, m[a]});
    rd(`GWWE_ADR_RDATA, {14'h0, m[a]});
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    stop_test;
  end
  initial begin : main
    int k, i, o;
    logic [15:0] a, c[4];
    logic [31:0] s, p;
    s = $urandom(32'h2f0a_5bb1);
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(`GWWE_ADR_CTRL, 32'h2);
    rd(`GWWE_ADR_WIN_H, 32'haf00);
    rd(`GWWE_ADR_WIN_V, 32'hef00);
    rd(`GWWE_ADR_MASK, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0);
    $display("reset test done");
    wr(`GWWE_ADR_WIN_H, 32'h0302);
    wr(`GWWE_ADR_WIN_V, 32'h0201);
    s = $urandom;
    cmp = s[17:0];
    wr(`GWWE_ADR_CMP, s);
    msk = 18'h0;
    bst = 1'b0;
    // four stepping modes, plain then both compare settings
    for (o = 0; o < 12; o++) begin
      lg = (o < 4) ? 3'h0 : (o < 8) ? 3'h6 : 3'h7;
      k = o % 4;
      s = $urandom;
      if (o > 0) msk = s[17:0];
      wr(`GWWE_ADR_MASK, {14'h0, msk});
      wr(`GWWE_ADR_CTRL, {26'h0, 1'b1, lg, k[1], k[0]});
      for (i = 0; i < 4; i++) begin
        a[15:8] = 8'(1 + (k[0] ? i % 2 : i / 2));
        a[7:0] = 8'(k[1] ? 2 + (k[0] ? i / 2 : i % 2)
                         : 3 - (k[0] ? i / 2 : i % 2));
        c[i] = a;
        if (i == 0) wr(`GWWE_ADR_ADDR, {16'h0, a});
        s = $urandom;
        if (lg != 3'h0 && i[0]) s[17:0] = cmp;
        put(a, s, s[17:0]);
      end
      repeat (3) @(posedge i_clock);
      if (k[1]) rd(`GWWE_ADR_ADDR, 32'h0102);
      for (i = 0; i < 4; i++) look(c[i]);
      $display("mode test %0d done", o);
    end
    msk = 18'h0;
    lg = 3'h0;
    wr(`GWWE_ADR_MASK, 32'h0);
    wr(`GWWE_ADR_CTRL, 32'h2);
    wr(`GWWE_ADR_ADDR, 32'h0102);
    s = $urandom;
    put(16'h0102, s, {s[15:11], s[15], s[10:5], s[4:0], s[4]});
    look(16'h0102);
    $display("narrow bus test done");
    bst = 1'b1;
    lg = 3'h6;
    wr(`GWWE_ADR_WIN_H, 32'h0704);
    wr(`GWWE_ADR_CTRL, 32'h7a);
    wr(`GWWE_ADR_ADDR, 32'h0104);
    for (i = 0; i < 4; i++) begin
      s = $urandom;
      s[17:12] = ~cmp[17:12];
      put(16'h0104 + 16'(i), s, s[17:0]);
    end
    for (i = 0; i < 4; i++) look(16'h0104 + 16'(i));
    $display("burst test done");
    s = $urandom;
    p = $urandom;
    wr(`GWWE_ADR_GAM_POS, s);
    wr(`GWWE_ADR_GAM_NEG, p);
    rd(`GWWE_ADR_GAM_POS, {6'h0, s[25:0]});
    rd(`GWWE_ADR_GAM_NEG, {6'h0, p[25:0]});
    wr(`GWWE_ADR_CTRL, 32'h2);
    repeat (2) @(posedge i_clock);
    chk({6'h0, gam}, {6'h0, s[25:0]});
    wr(`GWWE_ADR_CTRL, 32'h82);
    repeat (2) @(posedge i_clock);
    chk({6'h0, gam}, {6'h0, p[25:0]});
    $display("gamma test done");
    stop_test;
  end
endmodule // gwwe_top_bench

// ### hw/gwwe_defines.vh
// constants for the graphics ram window write engine
`ifndef GWWE_DEFINES_VH
`define GWWE_DEFINES_VH
`define GWWE_ADR_CTRL     8'h00
`define GWWE_ADR_WIN_H    8'h04
`define GWWE_ADR_WIN_V    8'h08
`define GWWE_ADR_ADDR     8'h0C
`define GWWE_ADR_MASK     8'h10
`define GWWE_ADR_CMP      8'h14
`define GWWE_ADR_DATA     8'h18
`define GWWE_ADR_STAT     8'h1C
`define GWWE_ADR_GAM_POS  8'h20
`define GWWE_ADR_GAM_NEG  8'h24
`define GWWE_ADR_RDATA    8'h28
`define GWWE_CTL_AXIS     0
`define GWWE_CTL_DIR      1
`define GWWE_CTL_LG_LO    2
`define GWWE_CTL_LG_HI    4
`define GWWE_CTL_BUS18    5
`define GWWE_CTL_BURST    6
`define GWWE_CTL_POL      7
`define GWWE_CTL_RST      8'h02
`define GWWE_H_MAX        8'hAF
`define GWWE_V_MAX        8'hEF
`define GWWE_LG_NONE      3'h0
`define GWWE_LG_CMP_EQ    3'h6
`define GWWE_LG_CMP_NE    3'h7
`define GWWE_GAM_W        26
`define GWWE_FIFO_DEPTH   16
`define GWWE_FIFO_AW      4
`endif

// ### hw/gwwe_fifo.v
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module gwwe_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clock,   // core clock
  input  wire             i_rstn,    // async reset, active low
  input  wire             i_valid,   // fill side valid
  output wire             o_ready,   // fill side ready (not full)
  input  wire [WIDTH-1:0] i_data,    // fill side word
  output wire             o_valid,   // drain side valid (not empty)
  input  wire             i_ready,   // drain side ready
  output wire [WIDTH-1:0] o_data     // drain side word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  // full and empty come straight from the occupancy count
  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data  = mem[rd_ptr];
  assign do_wr   = i_valid && o_ready;
  assign do_rd   = o_valid && i_ready;

  // pointers and occupancy
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end

  // storage has no reset; only written words are ever read
  always @(posedge i_clock) begin
    if (do_wr)
      mem[wr_ptr] <= i_data;
  end
endmodule // gwwe_fifo

// ### hw/gwwe_top.v
// graphics ram window write engine with wishbone register access
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "gwwe_defines.vh"
module gwwe_top (
  input  wire        i_clock,      // 40 MHz core clock
  input  wire        i_rstn,       // async reset, active low
  input  wire        i_wb_cyc,     // wishbone cycle
  input  wire        i_wb_stb,     // wishbone strobe
  input  wire        i_wb_we,      // wishbone write enable
  input  wire [7:0]  i_wb_adr,     // wishbone byte address
  input  wire [3:0]  i_wb_sel,     // wishbone byte selects
  input  wire [31:0] i_wb_dat,     // wishbone write data
  output reg  [31:0] o_wb_dat,     // wishbone read data
  output reg         o_wb_ack,     // wishbone acknowledge
  input  wire [15:0] i_rd_addr,    // display scan read address
  output reg  [17:0] o_rd_data,    // display scan read data
  output reg  [25:0] o_gamma_set   // gamma set for active polarity
);
  // ram is 176 x 240 words, row in high byte, column in low byte
  localparam RAM_WORDS = 42240;
  localparam [7:0] COLS = 8'd176;

  reg  [17:0] display_ram [0:RAM_WORDS-1];
  reg  [7:0]  ctrl;
  reg  [7:0]  win_h_start;
  reg  [7:0]  win_h_end;
  reg  [7:0]  win_v_start;
  reg  [7:0]  win_v_end;
  reg  [7:0]  ram_addr_row;
  reg  [7:0]  ram_addr_col;
  reg  [17:0] write_bit_mask;
  reg  [17:0] compare_value;
  reg  [25:0] gam_pos;
  reg  [25:0] gam_neg;
  reg  [15:0] word_cnt;
  reg  [15:0] skip_cnt;

  wire        addr_axis_sel  = ctrl[`GWWE_CTL_AXIS];
  wire        step_dir_bit0  = ctrl[`GWWE_CTL_DIR];
  wire [2:0]  logic_op_sel   = ctrl[`GWWE_CTL_LG_HI:`GWWE_CTL_LG_LO];
  wire        bus18          = ctrl[`GWWE_CTL_BUS18];
  wire        burst_write_mode = ctrl[`GWWE_CTL_BURST];
  wire        polarity_neg   = ctrl[`GWWE_CTL_POL];

  wire        wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire        wr_data  = wb_req && i_wb_we && (i_wb_adr == `GWWE_ADR_DATA);

  // byte-lane merge of a 32-bit write into an old value
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  // merged 32-bit images; each register keeps only its own width
  wire [31:0] ctrl_mrg = lane_merge({24'h00_0000, ctrl},
                                    i_wb_dat, i_wb_sel);
  wire [31:0] mask_mrg = lane_merge({14'h0000, write_bit_mask},
                                    i_wb_dat, i_wb_sel);
  wire [31:0] cmp_mrg  = lane_merge({14'h0000, compare_value},
                                    i_wb_dat, i_wb_sel);
  wire [31:0] gpos_mrg = lane_merge({6'h00, gam_pos}, i_wb_dat, i_wb_sel);
  wire [31:0] gneg_mrg = lane_merge({6'h00, gam_neg}, i_wb_dat, i_wb_sel);

  // 16-bit rgb565 to 18-bit rgb666, msb copied into the spare lsb
  function [17:0] expand16;
    input [15:0] d;
    begin
      expand16 = {d[15:11], d[15], d[10:5], d[4:0], d[4]};
    end
  endfunction

  // fifo between host data writes and the ram writer
  wire        fifo_in_rdy;
  wire        fifo_out_vld;
  wire [17:0] fifo_out;
  wire        fifo_out_rdy;

  gwwe_fifo #(
    .WIDTH (18),
    .DEPTH (`GWWE_FIFO_DEPTH),
    .AW    (`GWWE_FIFO_AW)
  ) u_fifo (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_valid (wr_data && fifo_in_rdy),
    .o_ready (fifo_in_rdy),
    .i_data  (bus18 ? i_wb_dat[17:0]
                    : expand16(i_wb_dat[15:0])),
    .o_valid (fifo_out_vld),
    .i_ready (fifo_out_rdy),
    .o_data  (fifo_out)
  );

  // ram writer drains one word per cycle, never stalls
  assign fifo_out_rdy = 1'b1;

  // compare per colour field; pass when every field meets the condition
  wire eq_r = (fifo_out[17:12] == compare_value[17:12]);
  wire eq_g = (fifo_out[11:6]  == compare_value[11:6]);
  wire eq_b = (fifo_out[5:0]   == compare_value[5:0]);
  wire is_cmp = (logic_op_sel == `GWWE_LG_CMP_EQ) ||
                (logic_op_sel == `GWWE_LG_CMP_NE);
  // burst mode disables compare so every word lands
  wire cmp_act = is_cmp && !burst_write_mode;
  wire cmp_ok  = (logic_op_sel == `GWWE_LG_CMP_EQ) ?
                 (eq_r && eq_g && eq_b) :
                 (!eq_r && !eq_g && !eq_b);
  wire do_write = fifo_out_vld && (!cmp_act || cmp_ok);
  wire in_win   = (ram_addr_col >= win_h_start) &&
                  (ram_addr_col <= win_h_end) &&
                  (ram_addr_row >= win_v_start) &&
                  (ram_addr_row <= win_v_end);
  wire [15:0] lin_addr = ram_addr_row * COLS + ram_addr_col;
  wire [17:0] old_word = display_ram[lin_addr];

  // masked merge: mask one keeps old bit, in every mode
  wire [17:0] new_word = (old_word & write_bit_mask) |
                         (fifo_out & ~write_bit_mask);

  // ram write; the address counter steps even if compare fails
  always @(posedge i_clock) begin
    if (do_write && in_win)
      display_ram[lin_addr] <= new_word;
  end

  // next address inside the window
  reg [7:0] next_col;
  reg [7:0] next_row;
  always @* begin
    next_col = ram_addr_col;
    next_row = ram_addr_row;
    if (!addr_axis_sel) begin
      if (step_dir_bit0) begin
        if (ram_addr_col >= win_h_end) begin
          next_col = win_h_start;
          next_row = (ram_addr_row >= win_v_end) ? win_v_start
                                                 : ram_addr_row + 8'h01;
        end else
          next_col = ram_addr_col + 8'h01;
      end else begin
        if (ram_addr_col <= win_h_start) begin
          next_col = win_h_end;
          next_row = (ram_addr_row >= win_v_end) ? win_v_start
                                                 : ram_addr_row + 8'h01;
        end else
          next_col = ram_addr_col - 8'h01;
      end
    end else begin
      // +256 is one row down; at bottom move to next column
      if (ram_addr_row >= win_v_end) begin
        next_row = win_v_start;
        if (step_dir_bit0)
          next_col = (ram_addr_col >= win_h_end) ? win_h_start
                                                 : ram_addr_col + 8'h01;
        else
          next_col = (ram_addr_col <= win_h_start) ? win_h_end
                                                   : ram_addr_col - 8'h01;
      end else
        next_row = ram_addr_row + 8'h01;
    end
  end

  // gamma set follows drive polarity, both held separately
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)
      o_gamma_set <= 26'h000_0000;
    else
      o_gamma_set <= polarity_neg ? gam_neg : gam_pos;
  end

  // display scan read port, registered
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)
      o_rd_data <= 18'h0_0000;
    else
      o_rd_data <= display_ram[i_rd_addr];
  end

  // register file, address counter and wishbone answer
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl           <= `GWWE_CTL_RST;
      win_h_start    <= 8'h00;
      win_h_end      <= `GWWE_H_MAX;
      win_v_start    <= 8'h00;
      win_v_end      <= `GWWE_V_MAX;
      ram_addr_row   <= 8'h00;
      ram_addr_col   <= 8'h00;
      write_bit_mask <= 18'h0_0000;
      compare_value  <= 18'h0_0000;
      gam_pos        <= 26'h000_0000;
      gam_neg        <= 26'h000_0000;
      word_cnt       <= 16'h0000;
      skip_cnt       <= 16'h0000;
      o_wb_ack       <= 1'b0;
      o_wb_dat       <= 32'h0000_0000;
    end else begin
      o_wb_ack <= 1'b0;
      // stepping per drained word; write to the address register wins
      if (fifo_out_vld) begin
        ram_addr_col <= next_col;
        ram_addr_row <= next_row;
        if (do_write && in_win)
          word_cnt <= word_cnt + 16'h0001;
        else
          skip_cnt <= skip_cnt + 16'h0001;
      end
      // data writes wait on a full fifo: ack withheld = back-pressure
      if (wb_req && !(wr_data && !fifo_in_rdy)) begin
        o_wb_ack <= 1'b1;
        o_wb_dat <= 32'h0000_0000;
        if (i_wb_we) begin
          case (i_wb_adr)
            `GWWE_ADR_CTRL:
              ctrl <= ctrl_mrg[7:0];
            `GWWE_ADR_WIN_H: begin
              if (i_wb_sel[0]) win_h_start <= i_wb_dat[7:0];
              if (i_wb_sel[1]) win_h_end   <= i_wb_dat[15:8];
            end
            `GWWE_ADR_WIN_V: begin
              if (i_wb_sel[0]) win_v_start <= i_wb_dat[7:0];
              if (i_wb_sel[1]) win_v_end   <= i_wb_dat[15:8];
            end
            `GWWE_ADR_ADDR: begin
              // host keeps this inside the window and burst aligned
              if (i_wb_sel[0]) ram_addr_col <= i_wb_dat[7:0];
              if (i_wb_sel[1]) ram_addr_row <= i_wb_dat[15:8];
            end
            `GWWE_ADR_MASK:
              write_bit_mask <= mask_mrg[17:0];
            `GWWE_ADR_CMP:
              compare_value <= cmp_mrg[17:0];
            `GWWE_ADR_GAM_POS:
              gam_pos <= gpos_mrg[25:0];
            `GWWE_ADR_GAM_NEG:
              gam_neg <= gneg_mrg[25:0];
            default: ;
          endcase
        end else begin
          case (i_wb_adr)
            `GWWE_ADR_CTRL:    o_wb_dat <= {24'h00_0000, ctrl};
            `GWWE_ADR_WIN_H:   o_wb_dat <= {16'h0000, win_h_end, win_h_start};
            `GWWE_ADR_WIN_V:   o_wb_dat <= {16'h0000, win_v_end, win_v_start};
            `GWWE_ADR_ADDR:    o_wb_dat <= {16'h0000, ram_addr_row,
                                            ram_addr_col};
            `GWWE_ADR_MASK:    o_wb_dat <= {14'h0000, write_bit_mask};
            `GWWE_ADR_CMP:     o_wb_dat <= {14'h0000, compare_value};
            `GWWE_ADR_STAT:    o_wb_dat <= {skip_cnt, word_cnt};
            `GWWE_ADR_GAM_POS: o_wb_dat <= {6'h00, gam_pos};
            `GWWE_ADR_GAM_NEG: o_wb_dat <= {6'h00, gam_neg};
            `GWWE_ADR_RDATA:   o_wb_dat <= {14'h0000, old_word};
            default:           o_wb_dat <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule // gwwe_top
